// file: mhu_dev.sv
/*
  device end: serial port, reset filter and init, configuration registers,
  digital output selection.
  assumes dev_reset_n and host_to_dev arrive asynchronously on the link;
  register port and event inputs come from logic on clk_i.
*/
// Our own choice: the APB register port.
// Operation
// - full-duplex asynchronous link over two data wires
// - ten-bit frame: start, eight data, stop
// - data bits travel least significant first
// - bit rate = divisor times clock over 524288
// - after reset 600 baud at 4.096MHz
// - at most 512K baud at 4.096MHz
// - reset low over 120us halts everything
// - reset release runs default-loading init sequence
// - device drives tx line, listens on rx
// - digital output carries one of four functions
// - current gain selects 10x or 50x
`timescale 1ns/1ps
`default_nettype none
`include "mhu_regs.svh"
module mhu_dev #(
  parameter int RST_HOLD_CYC = `MHU_RST_HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  mhu_link_if.dev link,
  input wire logic reg_wr_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic ev_pulse_i,
  input wire logic ev_irq_i,
  input wire logic ev_zc_i,
  input wire logic ev_dir_i,
  output logic gain_x50_o,
  output logic running_o
);
  localparam int CW = $clog2(RST_HOLD_CYC + 1);
  localparam logic [CW-1:0] HOLD = CW'(RST_HOLD_CYC);
  localparam logic [1:0] INIT_LAST = `MHU_DEV_SERCTL;
  typedef struct packed {
    mhu_pkg::mhu_dev_st_t st;
    logic [2:0] sync;
    logic filt;
    logic [CW-1:0] lowcnt;
    logic [1:0] init_idx;
    logic [23:0] cfg0;
    logic [23:0] outcfg;
    logic [23:0] serctl;
    logic ferr;
    logic [23:0] rdata;
    logic dout;
  } mhu_dev_reg_t;
  mhu_dev_reg_t r;
  mhu_dev_reg_t n;
  logic u_tx;
  logic u_rdy;
  logic u_rv;
  logic u_fe;
  logic [7:0] u_rd;
  logic run;

  function automatic logic [23:0] def_val(input logic [1:0] idx);
    case (idx)
      `MHU_DEV_CFG0: def_val = `MHU_CFG0_RESET;
      `MHU_DEV_OUTCFG: def_val = `MHU_OUTCFG_RESET;
      `MHU_DEV_SERCTL: def_val = 24'(`MHU_BAUD_DIV_DEFAULT);
      default: def_val = 24'h000000;
    endcase
  endfunction

  assign run = (r.st == mhu_pkg::DEV_RUN);

  mhu_uart u_uart (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .soft_rst_i(!run),
    .divisor_i(r.serctl[15:0]),
    .rx_pin_i(link.host_to_dev),
    .tx_pin_o(u_tx),
    .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i && run),
    .tx_ready_o(u_rdy),
    .rx_data_o(u_rd),
    .rx_valid_o(u_rv),
    .rx_ferr_o(u_fe)
  );

  always_comb
  begin
    n = r;
    // reset pin filter
    n.sync = {r.sync[1:0], link.dev_reset_n};
    if (r.sync[1] == r.sync[2])
    begin
      n.filt = r.sync[2];
    end
    if (r.filt)
    begin
      n.lowcnt = '0;
    end
    else if (r.lowcnt != HOLD)
    begin
      n.lowcnt = r.lowcnt + 1'b1;
    end
    case (r.st)
      mhu_pkg::DEV_RUN:
      begin
        if (reg_wr_i)
        begin
          case (reg_addr_i)
            `MHU_DEV_CFG0: n.cfg0 = reg_wdata_i;
            `MHU_DEV_OUTCFG: n.outcfg = reg_wdata_i;
            `MHU_DEV_SERCTL: n.serctl = reg_wdata_i;
            `MHU_DEV_DSTAT: n.ferr = r.ferr && !reg_wdata_i[0];
            default: n.ferr = r.ferr;
          endcase
        end
        if (u_fe)
        begin
          n.ferr = 1'b1;
        end
      end
      mhu_pkg::DEV_HALT:
      begin
        n.cfg0 = 24'h000000;
        n.outcfg = 24'h000000;
        n.serctl = 24'h000000;
        n.ferr = 1'b0;
        if (r.filt)
        begin
          n.st = mhu_pkg::DEV_INIT;
          n.init_idx = 2'h0;
        end
      end
      mhu_pkg::DEV_INIT:
      begin
        case (r.init_idx)
          `MHU_DEV_CFG0: n.cfg0 = def_val(r.init_idx);
          `MHU_DEV_OUTCFG: n.outcfg = def_val(r.init_idx);
          default: n.serctl = def_val(r.init_idx);
        endcase
        if (r.init_idx == INIT_LAST)
        begin
          n.st = mhu_pkg::DEV_RUN;
        end
        else
        begin
          n.init_idx = r.init_idx + 2'h1;
        end
      end
      default: n.st = mhu_pkg::DEV_HALT;
    endcase
    if (r.lowcnt == HOLD)
    begin
      n.st = mhu_pkg::DEV_HALT;
    end
    case (reg_addr_i)
      `MHU_DEV_CFG0: n.rdata = r.cfg0;
      `MHU_DEV_OUTCFG: n.rdata = r.outcfg;
      `MHU_DEV_SERCTL: n.rdata = r.serctl;
      default: n.rdata = {22'h0, run, r.ferr};
    endcase
    n.dout = 1'b0;
    if (run)
    begin
      case (mhu_pkg::mhu_do_sel_t'(r.outcfg[1:0]))
        mhu_pkg::DO_PULSE: n.dout = ev_pulse_i;
        mhu_pkg::DO_IRQ: n.dout = ev_irq_i;
        mhu_pkg::DO_ZC: n.dout = ev_zc_i;
        mhu_pkg::DO_DIR: n.dout = ev_dir_i;
        default: n.dout = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= mhu_pkg::DEV_INIT;
      r.sync <= 3'h7;
      r.filt <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // device drives only its transmit line and dig_out
  assign link.dev_to_host = u_tx;
  assign link.dig_out = r.dout;
  assign reg_rdata_o = r.rdata;
  assign tx_ready_o = u_rdy;
  assign rx_data_o = u_rd;
  assign rx_valid_o = u_rv;
  assign gain_x50_o = r.cfg0[`MHU_CFG0_GAIN_BIT];
  assign running_o = run;
endmodule
`default_nettype wire

// file: mhu_regs.svh
/*
  constants for the metering host uart port: timing, frame, register map.
  assumes a 100 MHz system clock shared by both ends.
*/
`ifndef MHU_REGS_SVH
`define MHU_REGS_SVH
`define MHU_CLK_MHZ 100
`define MHU_FRAME_BITS 10
`define MHU_OVS 8
`define MHU_BAUD_SCALE 524288
`define MHU_BAUD_DEF_RATE 600
`define MHU_REF_MCLK_HZ 4096000
`define MHU_BAUD_DIV_DEFAULT ((`MHU_BAUD_DEF_RATE*`MHU_BAUD_SCALE+`MHU_REF_MCLK_HZ/2)/`MHU_REF_MCLK_HZ)
`define MHU_RST_HOLD_NS 120000
`define MHU_RST_HOLD_CYC ((`MHU_RST_HOLD_NS*`MHU_CLK_MHZ)/1000)
`define MHU_RST_MARGIN_CYC 100
`define MHU_DEV_CFG0 2'h0
`define MHU_DEV_OUTCFG 2'h1
`define MHU_DEV_SERCTL 2'h2
`define MHU_DEV_DSTAT 2'h3
`define MHU_CFG0_RESET 24'h000000
`define MHU_OUTCFG_RESET 24'h000000
`define MHU_CFG0_GAIN_BIT 0
`define MHU_A_CTRL 12'h000
`define MHU_A_TXD 12'h004
`define MHU_A_RXD 12'h008
`define MHU_A_STAT 12'h00C
`define MHU_A_MASK 12'h010
`define MHU_CTRL_RST_BIT 16
`define MHU_ST_RX 0
`define MHU_ST_TXT 1
`define MHU_ST_FERR 2
`define MHU_ST_OVR 3
`define MHU_ST_RSTD 4
`define MHU_ST_W 5
`endif

// file: mhu_pkg.sv
/*
  types for the metering host uart port.
  assumes nothing beyond the regs header.
*/
`default_nettype none
package mhu_pkg;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} mhu_tx_st_t;
  typedef enum logic [0:0] {RX_IDLE, RX_RECV} mhu_rx_st_t;
  typedef enum logic [1:0] {DEV_RUN, DEV_HALT, DEV_INIT} mhu_dev_st_t;
  typedef enum logic [1:0] {DO_PULSE, DO_IRQ, DO_ZC, DO_DIR} mhu_do_sel_t;
endpackage
`default_nettype wire

// file: mhu_link_if.sv
/*
  serial link between device end and host end.
  assumes the testbench instantiates it and joins both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface mhu_link_if;
  logic dev_to_host;
  logic host_to_dev;
  logic dev_reset_n;
  logic dig_out;
  modport dev (output dev_to_host, output dig_out, input host_to_dev, input dev_reset_n);
  modport host (input dev_to_host, input dig_out, output host_to_dev, output dev_reset_n);
endinterface
`default_nettype wire

// file: mhu_uart.sv
/*
  uart engine: fractional baud generator, transmitter, receiver.
  assumes rx_pin_i is asynchronous; all else on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhu_regs.svh"
module mhu_uart (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic [15:0] divisor_i,
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_ferr_o
);
  localparam int TKW = $clog2(`MHU_OVS);
  localparam logic [TKW-1:0] TK_LAST = TKW'(`MHU_OVS - 1);
  localparam logic [TKW-1:0] TK_MID = TKW'(`MHU_OVS / 2 - 1);
  localparam logic [3:0] BIT_LAST = 4'(`MHU_FRAME_BITS - 1);
  typedef struct packed {
    logic [15:0] acc;
    logic tick;
    mhu_pkg::mhu_tx_st_t tx_st;
    logic [8:0] tx_sh;
    logic [3:0] tx_bit;
    logic [TKW-1:0] tx_tk;
    logic txd;
    logic [2:0] sync;
    logic filt;
    mhu_pkg::mhu_rx_st_t rx_st;
    logic [3:0] rx_bit;
    logic [TKW-1:0] rx_tk;
    logic [7:0] rx_sh;
    logic [7:0] rx_dat;
    logic rx_v;
    logic rx_e;
  } mhu_uart_st_t;
  mhu_uart_st_t r;
  mhu_uart_st_t n;
  always_comb
  begin
    n = r;
    n.rx_v = 1'b0;
    n.rx_e = 1'b0;
    // eight ticks per bit: rate = div * clk / 524288
    {n.tick, n.acc} = {1'b0, r.acc} + {1'b0, divisor_i};
    n.sync = {r.sync[1:0], rx_pin_i};
    if (r.sync[1] == r.sync[2])
    begin
      n.filt = r.sync[2];
    end
    case (r.tx_st)
      mhu_pkg::TX_IDLE:
        if (tx_valid_i)
        begin
          n.tx_st = mhu_pkg::TX_SHIFT;
          n.tx_sh = {1'b1, tx_data_i};
          n.txd = 1'b0;
          n.tx_bit = 4'h0;
          n.tx_tk = '0;
        end
      mhu_pkg::TX_SHIFT:
        if (r.tick)
        begin
          n.tx_tk = r.tx_tk + 1'b1;
          if (r.tx_tk == TK_LAST)
          begin
            if (r.tx_bit == BIT_LAST)
            begin
              n.tx_st = mhu_pkg::TX_IDLE;
            end
            else
            begin
              n.txd = r.tx_sh[0];
              n.tx_sh = {1'b1, r.tx_sh[8:1]};
              n.tx_bit = r.tx_bit + 4'h1;
            end
          end
        end
      default: n.tx_st = mhu_pkg::TX_IDLE;
    endcase
    case (r.rx_st)
      mhu_pkg::RX_IDLE:
        if (!r.filt)
        begin
          n.rx_st = mhu_pkg::RX_RECV;
          n.rx_tk = '0;
          n.rx_bit = 4'h0;
        end
      mhu_pkg::RX_RECV:
        if (r.tick)
        begin
          n.rx_tk = r.rx_tk + 1'b1;
          if (r.rx_tk == TK_MID)
          begin
            n.rx_bit = r.rx_bit + 4'h1;
            if (r.rx_bit == 4'h0)
            begin
              if (r.filt)
              begin
                n.rx_st = mhu_pkg::RX_IDLE;
              end
            end
            else if (r.rx_bit == BIT_LAST)
            begin
              n.rx_st = mhu_pkg::RX_IDLE;
              n.rx_v = r.filt;
              n.rx_e = !r.filt;
              if (r.filt)
              begin
                n.rx_dat = r.rx_sh;
              end
            end
            else
            begin
              n.rx_sh = {r.filt, r.rx_sh[7:1]};
            end
          end
        end
      default: n.rx_st = mhu_pkg::RX_IDLE;
    endcase
    if (soft_rst_i)
    begin
      n.tx_st = mhu_pkg::TX_IDLE;
      n.rx_st = mhu_pkg::RX_IDLE;
      n.txd = 1'b1;
      n.acc = 16'h0000;
      n.tick = 1'b0;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.txd <= 1'b1;
      r.sync <= 3'h7;
      r.filt <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end
  assign tx_pin_o = r.txd;
  assign tx_ready_o = (r.tx_st == mhu_pkg::TX_IDLE) && !soft_rst_i;
  assign rx_data_o = r.rx_dat;
  assign rx_valid_o = r.rx_v;
  assign rx_ferr_o = r.rx_e;
endmodule
`default_nettype wire

// file: mhu_host.sv
/*
  host end: apb slave registers driving the serial link and device reset.
  assumes an apb master on clk_i; link inputs are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhu_regs.svh"
module mhu_host #(
  parameter int RST_PULSE_CYC = `MHU_RST_HOLD_CYC + `MHU_RST_MARGIN_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  mhu_link_if.host link
);
  localparam int CW = $clog2(RST_PULSE_CYC + 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(RST_PULSE_CYC - 1);
  typedef struct packed {
    logic [15:0] div;
    logic rst_req;
    logic [CW-1:0] rst_cnt;
    logic txq_v;
    logic [7:0] txq_d;
    logic [7:0] rxd;
    logic [`MHU_ST_W-1:0] stat;
    logic [`MHU_ST_W-1:0] mask;
    logic [2:0] dsync;
    logic dfilt;
    logic [31:0] prdata;
  } mhu_host_reg_t;
  mhu_host_reg_t r;
  mhu_host_reg_t n;
  logic u_rdy;
  logic u_rv;
  logic u_fe;
  logic [7:0] u_rd;
  logic wr;
  logic [`MHU_ST_W-1:0] st_set;
  logic [`MHU_ST_W-1:0] st_clr;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `MHU_A_CTRL) || (a == `MHU_A_TXD) || (a == `MHU_A_RXD) ||
               (a == `MHU_A_STAT) || (a == `MHU_A_MASK);
  endfunction

  mhu_uart u_uart (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .soft_rst_i(r.rst_req),
    .divisor_i(r.div),
    .rx_pin_i(link.dev_to_host),
    .tx_pin_o(link.host_to_dev),
    .tx_data_i(r.txq_d),
    .tx_valid_i(r.txq_v),
    .tx_ready_o(u_rdy),
    .rx_data_o(u_rd),
    .rx_valid_o(u_rv),
    .rx_ferr_o(u_fe)
  );

  assign wr = psel_i && penable_i && pwrite_i && addr_hit(paddr_i);

  always_comb
  begin
    n = r;
    st_set = '0;
    st_clr = '0;
    n.dsync = {r.dsync[1:0], link.dig_out};
    if (r.dsync[1] == r.dsync[2])
    begin
      n.dfilt = r.dsync[2];
    end
    if (r.txq_v && u_rdy)
    begin
      n.txq_v = 1'b0;
      st_set[`MHU_ST_TXT] = 1'b1;
    end
    if (u_rv)
    begin
      n.rxd = u_rd;
      st_set[`MHU_ST_RX] = 1'b1;
    end
    st_set[`MHU_ST_FERR] = u_fe;
    if (r.rst_req)
    begin
      n.rst_cnt = r.rst_cnt + 1'b1;
      if (r.rst_cnt == PULSE_LAST)
      begin
        n.rst_req = 1'b0;
        n.div = 16'(`MHU_BAUD_DIV_DEFAULT);
        st_set[`MHU_ST_RSTD] = 1'b1;
      end
    end
    if (wr)
    begin
      case (paddr_i)
        `MHU_A_CTRL:
        begin
          n.div = pwdata_i[15:0];
          if (pwdata_i[`MHU_CTRL_RST_BIT] && !r.rst_req)
          begin
            n.rst_req = 1'b1;
            n.rst_cnt = '0;
          end
        end
        `MHU_A_TXD:
          if (r.txq_v || r.rst_req)
          begin
            st_set[`MHU_ST_OVR] = 1'b1;
          end
          else
          begin
            n.txq_v = 1'b1;
            n.txq_d = pwdata_i[7:0];
          end
        `MHU_A_STAT: st_clr = pwdata_i[`MHU_ST_W-1:0];
        `MHU_A_MASK: n.mask = pwdata_i[`MHU_ST_W-1:0];
        default: n.mask = r.mask;
      endcase
    end
    // set wins over a clear in the same cycle
    n.stat = (r.stat & ~st_clr) | st_set;
    if (psel_i && !penable_i)
    begin
      case (paddr_i)
        `MHU_A_CTRL: n.prdata = {15'h0, r.rst_req, r.div};
        `MHU_A_TXD: n.prdata = {23'h0, r.txq_v, r.txq_d};
        `MHU_A_RXD: n.prdata = {24'h0, r.rxd};
        `MHU_A_STAT: n.prdata = {21'h0, r.dfilt, !u_rdy, r.rst_req, 3'h0, r.stat};
        `MHU_A_MASK: n.prdata = {27'h0, r.mask};
        default: n.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.div <= 16'(`MHU_BAUD_DIV_DEFAULT);
      r.dsync <= 3'h0;
    end
    else
    begin
      r <= n;
    end
  end

  assign link.dev_reset_n = !r.rst_req;
  assign prdata_o = r.prdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_hit(paddr_i);
  assign irq_o = |(r.stat & r.mask);
endmodule
`default_nettype wire

// file: mhu_link_properties.sv
/*
  concurrent checks on the serial link joining device end and host end.
  assumes both divisors hold 0x2000 (64 clocks a bit) whenever frames run.
*/
`timescale 1ns/1ps
`default_nettype none
module mhu_link_properties #(
  parameter int BIT_CYC = 64,
  parameter int HALT_CYC = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dev_to_host,
  input wire logic host_to_dev,
  input wire logic dev_reset_n,
  input wire logic dig_out
);
  typedef struct packed {logic da; logic ha; logic [9:0] dc; logic [9:0] hc; logic [5:0] rc;} mhu_mon_t;
  localparam int FRAME_END = BIT_CYC * 10 - 20;
  mhu_mon_t mon_r;
  mhu_mon_t mon_nxt;
  // frame position counters, one per direction, plus reset-low length
  always_comb
  begin
    mon_nxt = mon_r;
    if (!mon_r.da && !dev_to_host)
    begin
      mon_nxt.da = 1'b1;
      mon_nxt.dc = 10'h001;
    end
    else if (mon_r.da)
    begin
      mon_nxt.dc = mon_r.dc + 10'h001;
      mon_nxt.da = (int'(mon_r.dc) != FRAME_END);
    end
    if (!mon_r.ha && !host_to_dev)
    begin
      mon_nxt.ha = 1'b1;
      mon_nxt.hc = 10'h001;
    end
    else if (mon_r.ha)
    begin
      mon_nxt.hc = mon_r.hc + 10'h001;
      mon_nxt.ha = (int'(mon_r.hc) != FRAME_END);
    end
    if (dev_reset_n)
      mon_nxt.rc = 6'h00;
    else if (mon_r.rc != 6'h3F)
      mon_nxt.rc = mon_r.rc + 6'h01;
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      mon_r <= '0;
    else
      mon_r <= mon_nxt;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence pulse_low_s;
    !dev_reset_n [*8];
  endsequence
  sequence pulse_end_s;
    ##[1:1000] dev_reset_n;
  endsequence
  AST_DEV_START: assert property (mon_r.da && int'(mon_r.dc) == BIT_CYC / 2 |-> !dev_to_host)
    else $error("device start bit not low at mid bit");
  AST_HOST_START: assert property (mon_r.ha && int'(mon_r.hc) == BIT_CYC / 2 |-> !host_to_dev)
    else $error("host start bit not low at mid bit");
  AST_DEV_STOP: assert property (mon_r.da && int'(mon_r.dc) == BIT_CYC * 19 / 2 |-> dev_to_host)
    else $error("device stop bit not high");
  AST_HOST_STOP: assert property (mon_r.ha && int'(mon_r.hc) == BIT_CYC * 19 / 2 |-> host_to_dev)
    else $error("host stop bit not high");
  AST_DEV_STEADY: assert property (mon_r.da && int'(mon_r.dc) % BIT_CYC >= BIT_CYC / 4
    && int'(mon_r.dc) % BIT_CYC < BIT_CYC * 3 / 4 |-> $stable(dev_to_host))
    else $error("device line moved inside a bit");
  AST_HOST_STEADY: assert property (mon_r.ha && int'(mon_r.hc) % BIT_CYC >= BIT_CYC / 4
    && int'(mon_r.hc) % BIT_CYC < BIT_CYC * 3 / 4 |-> $stable(host_to_dev))
    else $error("host line moved inside a bit");
  AST_IDLE_REL: assert property ($fell(rst_i) |-> dev_to_host && host_to_dev && dev_reset_n)
    else $error("link not idle after reset");
  AST_RST_PULSE: assert property ($fell(dev_reset_n) |-> pulse_low_s ##0 pulse_end_s)
    else $error("device reset pulse malformed");
  AST_HALT_QUIET: assert property (int'(mon_r.rc) >= HALT_CYC |-> dev_to_host && !dig_out)
    else $error("device active while held in reset");
endmodule
`default_nettype wire

// file: testbench.sv
/*
  testbench: both ends joined by the link; apb master and device-side stimulus.
  assumes the regs header and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhu_regs.svh"
module testbench;
  localparam int DIV_DEF = (600 * 524288 + 4096000 / 2) / 4096000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic wr = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] rdata;
  logic [7:0] txd = 8'h00;
  logic txv = 1'b0;
  logic txr;
  logic [7:0] rxd;
  logic rxv;
  logic [3:0] ev = 4'h0;
  logic gain;
  logic run;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int rx_cnt = 0;
  logic [7:0] rx_last = 8'h00;
  logic [31:0] r;
  logic e;
  logic [9:0] fb;
  logic sel_h2d = 1'b0;
  logic mon;
  mhu_link_if link();
  mhu_dev #(.RST_HOLD_CYC(12)) i_mhu_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .tx_data_i(txd), .tx_valid_i(txv),
    .tx_ready_o(txr), .rx_data_o(rxd), .rx_valid_o(rxv), .ev_pulse_i(ev[0]), .ev_irq_i(ev[1]),
    .ev_zc_i(ev[2]), .ev_dir_i(ev[3]), .gain_x50_o(gain), .running_o(run));
  mhu_host #(.RST_PULSE_CYC(30)) i_mhu_host (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .link(link));
  mhu_link_properties #(.BIT_CYC(64), .HALT_CYC(24)) i_mhu_link_properties (.clk_i(clk_i), .rst_i(rst_i),
    .dev_to_host(link.dev_to_host), .host_to_dev(link.host_to_dev), .dev_reset_n(link.dev_reset_n),
    .dig_out(link.dig_out));
  assign mon = sel_h2d ? link.host_to_dev : link.dev_to_host;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (rxv === 1'b1)
    begin
      rx_last <= rxd;
      rx_cnt <= rx_cnt + 1;
    end
    if (cyc == 60000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dwr(input logic [1:0] a, input logic [23:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic drd(input logic [1:0] a);
    @(posedge clk_i);
    addr <= a;
    repeat (2) @(posedge clk_i);
    #1 r = {8'h00, rdata};
  endtask
  task automatic dtx(input logic [7:0] b);
    @(posedge clk_i);
    txd <= b;
    txv <= 1'b1;
    @(posedge clk_i);
    while (txr !== 1'b1) @(posedge clk_i);
    txv <= 1'b0;
  endtask
  // sample one frame at mid bit, start bit first
  task automatic cap(input logic s);
    sel_h2d = s;
    while (mon !== 1'b0) @(posedge clk_i);
    repeat (32) @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      fb[i] = mon;
      repeat (64) @(posedge clk_i);
    end
  endtask
  task automatic h2d(input logic [7:0] b);
    apb(1'b1, `MHU_A_TXD, {24'h0, b});
    cap(1'b1);
    chk("h2d_frame", {22'h0, 1'b1, b, 1'b0}, {22'h0, fb});
    chk("dev_rx", {24'h0, b}, {24'h0, rx_last});
  endtask
  task automatic d2h(input logic [7:0] b, input logic im);
    dtx(b);
    cap(1'b0);
    chk("d2h_frame", {22'h0, 1'b1, b, 1'b0}, {22'h0, fb});
    apb(1'b0, `MHU_A_RXD, 32'h0);
    chk("host_rx", {24'h0, b}, {24'h0, r[7:0]});
    apb(1'b0, `MHU_A_STAT, 32'h0);
    chk("rx_flag", 32'h1, {31'h0, r[0]});
    chk("irq", {31'h0, im}, {31'h0, irq});
    apb(1'b1, `MHU_A_STAT, 32'h1F);
    #1 chk("irq_clr", 32'h0, {31'h0, irq});
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    while (run !== 1'b1) @(posedge clk_i);
    apb(1'b0, `MHU_A_CTRL, 32'h0);
    chk("host_div", DIV_DEF, {16'h0, r[15:0]});
    drd(2'h2);
    chk("dev_div", DIV_DEF, {16'h0, r[15:0]});
    drd(2'h3);
    chk("dev_stat", 32'h2, r);
    apb(1'b1, `MHU_A_CTRL, 32'h00002000);
    dwr(2'h2, 24'h002000);
    apb(1'b1, `MHU_A_MASK, 32'h1);
    h2d(8'hA5);
    h2d(8'h01);
    h2d(8'h80);
    d2h(8'h3C, 1'b1);
    apb(1'b1, `MHU_A_MASK, 32'h0);
    d2h(8'hC3, 1'b0);
    apb(1'b1, `MHU_A_TXD, 32'h5A);
    dtx(8'h96);
    repeat (800) @(posedge clk_i);
    chk("fd_dev", 32'h5A, {24'h0, rx_last});
    chk("dev_rx_count", 32'h4, 32'(rx_cnt));
    apb(1'b0, `MHU_A_RXD, 32'h0);
    chk("fd_host", 32'h96, {24'h0, r[7:0]});
    for (int k = 0; k < 4; k++)
    begin
      dwr(2'h1, 24'(k));
      ev <= 4'h1 << k;
      repeat (2) @(posedge clk_i);
      ev <= ~(4'h1 << k);
      #1 chk("dig_sel_hi", 32'h1, {31'h0, link.dig_out});
      repeat (2) @(posedge clk_i);
      #1 chk("dig_sel_lo", 32'h0, {31'h0, link.dig_out});
    end
    for (int g = 0; g < 2; g++)
    begin
      dwr(2'h0, 24'(g));
      #1 chk("gain", 32'(g), {31'h0, gain});
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapped_rd", 32'h0, r);
    apb(1'b1, `MHU_A_CTRL, 32'h00012000);
    while (run !== 1'b0) @(posedge clk_i);
    while (run !== 1'b1) @(posedge clk_i);
    #1 chk("gain_rst", 32'h0, {31'h0, gain});
    drd(2'h2);
    chk("dev_div_rst", DIV_DEF, {16'h0, r[15:0]});
    apb(1'b0, `MHU_A_CTRL, 32'h0);
    chk("host_div_rst", DIV_DEF, {16'h0, r[15:0]});
    apb(1'b0, `MHU_A_STAT, 32'h0);
    chk("rst_done", 32'h1, {31'h0, r[4]});
    summarize();
  end
endmodule
`default_nettype wire
